// ===== verilog/ubg_consts.svh
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// register byte offsets on the bus
`define UBG_ADR_GEN_CTRL 8'h00
`define UBG_ADR_RELOAD_LO 8'h04
`define UBG_ADR_RELOAD_HI 8'h08
`define UBG_ADR_BAUD_CTRL 8'h0c
`define UBG_ADR_FRAC_DIV 8'h10
`define UBG_ADR_POWER 8'h14
`define UBG_ADR_CLOCK 8'h18
`define UBG_ADR_COUNT 8'h1c
`define UBG_ADR_SOURCE 8'h20

// general timer control fields
`define UBG_GEN_RX_SEL 5
`define UBG_GEN_TX_SEL 4
`define UBG_GEN_RUN 2

// dedicated baud timer control fields
`define UBG_BAUD_EN 7
`define UBG_BAUD_DIV_HI 2

// power control and clock control fields
`define UBG_PWR_DOUBLE 7
`define UBG_CLK_DIV_HI 2

// reset values
`define UBG_RST_BYTE 8'h00
`define UBG_RST_COUNT 16'h0000

// timing counts
`define UBG_GEN_TOP 16'hffff
`define UBG_OVF_LAST 4'hf
`define UBG_T1_LAST_X1 5'h1f
`define UBG_T1_LAST_X2 5'h0f
`define UBG_FD_OFFSET 9'h040
`define UBG_FD_STEP 9'h002
`define UBG_SHIFT_LAST 6'h0b
`define UBG_FIX_LAST_X1 6'h3f
`define UBG_FIX_LAST_X2 6'h1f

`endif

// ===== verilog/ubg_pkg.sv
package ubg_pkg;

  // serial port operating modes
  typedef enum logic [1:0] {
    UBG_MODE_SHIFT = 2'b00,
    UBG_MODE_VAR8 = 2'b01,
    UBG_MODE_FIX9 = 2'b10,
    UBG_MODE_VAR9 = 2'b11
  } ubg_mode_type;

  // bit-rate source per direction, as shown in the source register
  typedef enum logic [1:0] {
    UBG_SRC_FIXED = 2'b00,
    UBG_SRC_TIMER1 = 2'b01,
    UBG_SRC_GENERAL = 2'b10,
    UBG_SRC_DEDICATED = 2'b11
  } ubg_src_type;

  // all-ones mask of width n, i.e. two to the n minus one
  function automatic logic [6:0] ubg_pow2_mask(input logic [2:0] n);
    ubg_pow2_mask = 7'((8'h01 << n) - 8'h01);
  endfunction

endpackage

// ===== verilog/ubg_frac_timer.sv
`timescale 1ns/1ns
`include "ubg_consts.svh"

module ubg_frac_timer
  import ubg_pkg::*;
#(
  parameter int FD_WIDTH = 8
) (
  // system
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic core_tick,
  input wire logic enable,
  input wire logic [2:0] div_sel,
  input wire logic [FD_WIDTH-1:0] frac_div,
  // result
  output logic bit_tick
);

  if (FD_WIDTH != 8) begin : g_chk
    $error("ubg_frac_timer: FD_WIDTH must be 8");
  end

  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic [8:0] acc_q;
  logic [8:0] acc_d;
  logic tick_q;
  logic tick_d;

  // binary prescale by two to the power of the divider field
  wire [6:0] pre_mask = ubg_pow2_mask(div_sel); // [RULE7]
  wire pre_tick = enable && core_tick && ((pre_q & pre_mask) == pre_mask); // [RULE7]

  // period of (fd+64)/2 prescaled ticks, kept fractional in the accumulator
  wire [8:0] modulus = {1'b0, frac_div} + `UBG_FD_OFFSET; // [RULE8]
  wire [8:0] acc_step = acc_q + `UBG_FD_STEP; // [RULE8]
  wire acc_wrap = acc_step >= modulus; // [RULE11]

  assign pre_d = !enable ? 7'h00 : (core_tick ? 7'(pre_q + 7'h01) : pre_q);
  assign acc_d = !enable ? 9'h000 :
                 (!pre_tick ? acc_q : (acc_wrap ? 9'(acc_step - modulus) : acc_step));
  assign tick_d = pre_tick && acc_wrap;
  assign bit_tick = tick_q;

  // prescaler, accumulator and tick registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_q <= 7'h00;
      acc_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_FRAC_BOUND: assert property ( // [RULE8]
    enable && acc_q < modulus |=> acc_q < modulus || $changed(frac_div))
    else $error("fractional accumulator left its modulus");
  AST_FRAC_PRESCALE: assert property (tick_q |-> $past(core_tick) && $past(enable)) // [RULE7]
    else $error("dedicated tick without a prescaled core tick");

endmodule

// ===== verilog/ubg_baud_gen.sv
`timescale 1ns/1ns
`include "ubg_consts.svh"
// Behaviour
// RULE1 - general timer gives one bit per sixteen overflows
// RULE2 - general timer advances once every two core clock cycles
// RULE3 - general timer reloads its full 16-bit count on each overflow
// RULE4 - tx and rx clock selects pick the general timer per direction
// RULE5 - general timer rate is core clock over 32 times counts to overflow
// RULE6 - baud timer enable overrides rate doubling and both clock selects
// RULE7 - dedicated timer prescales by two to the divider field
// RULE8 - dedicated rate is twice core over prescale times divider plus 64
// RULE9 - software picks divider as log2 of core over 32 times rate
// RULE10 - software picks divider value rounded from the rate formula minus 64
// RULE11 - dedicated timer reaches 12 to 393216 bits per second closely
// RULE12 - core frequency follows the clock control divider field
// RULE13 - timer rates serve only variable modes; other modes divide fixed
// RULE14 - dedicated timer enable is clear after reset
module ubg_baud_gen
  import ubg_pkg::*;
#(
  parameter int TIMER_WIDTH = 16,
  parameter int FD_WIDTH = 8
) (
  // system
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial port side
  input wire logic [1:0] serial_mode,
  input wire logic timer1_overflow,
  output logic tx_bit_tick,
  output logic rx_bit_tick
);

  if (TIMER_WIDTH != 16 || FD_WIDTH != 8) begin : g_chk
    $error("ubg_baud_gen: TIMER_WIDTH must be 16 and FD_WIDTH 8");
  end

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] gen_ctrl_q;
  logic [7:0] reload_lo_q;
  logic [7:0] reload_hi_q;
  logic [7:0] baud_ctrl_q;
  logic [7:0] frac_div_q;
  logic [7:0] power_q;
  logic [7:0] clock_ctrl_q;
  logic [6:0] cd_q;
  logic [15:0] gen_q;
  logic [15:0] gen_d;
  logic gen_phase_q;
  logic [3:0] tx_ovf_q;
  logic [3:0] rx_ovf_q;
  logic [4:0] t1_q;
  logic [5:0] fix_q;
  logic [5:0] fix_d;
  logic tx_q;
  logic rx_q;
  logic bt_tick;

  // bus decode: one word per register, data in byte lane 0
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_wr = bus_req && wb_we_i && ack_q && wb_sel_i[0];
  wire wr_gen = bus_wr && (wb_adr_i == `UBG_ADR_GEN_CTRL);
  wire wr_lo = bus_wr && (wb_adr_i == `UBG_ADR_RELOAD_LO);
  wire wr_hi = bus_wr && (wb_adr_i == `UBG_ADR_RELOAD_HI);
  wire wr_baud = bus_wr && (wb_adr_i == `UBG_ADR_BAUD_CTRL);
  wire wr_fd = bus_wr && (wb_adr_i == `UBG_ADR_FRAC_DIV);
  wire wr_pwr = bus_wr && (wb_adr_i == `UBG_ADR_POWER);
  wire wr_clk = bus_wr && (wb_adr_i == `UBG_ADR_CLOCK);
  wire [7:0] wbyte = wb_dat_i[7:0];

  // decoded control bits
  wire tx_sel = gen_ctrl_q[`UBG_GEN_TX_SEL];
  wire rx_sel = gen_ctrl_q[`UBG_GEN_RX_SEL];
  wire gen_run = gen_ctrl_q[`UBG_GEN_RUN];
  wire baud_en = baud_ctrl_q[`UBG_BAUD_EN];
  wire [2:0] bt_div = baud_ctrl_q[`UBG_BAUD_DIV_HI:0];
  wire rate_double_bit = power_q[`UBG_PWR_DOUBLE];
  wire [2:0] cd_sel = clock_ctrl_q[`UBG_CLK_DIV_HI:0];
  wire [15:0] reload_val = {reload_hi_q, reload_lo_q};
  ubg_mode_type mode;
  assign mode = ubg_mode_type'(serial_mode);
  wire var_mode = (mode == UBG_MODE_VAR8) || (mode == UBG_MODE_VAR9);

  // core clock enable: one pulse every two to the divider field clocks
  wire [6:0] cd_mask = ubg_pow2_mask(cd_sel); // [RULE12]
  wire core_tick = (cd_q & cd_mask) == cd_mask; // [RULE12]

  // general timer in baud generator mode, stepping on every second core tick
  wire gen_mode = (tx_sel || rx_sel) && gen_run; // [RULE4]
  wire gen_adv = gen_mode && core_tick && gen_phase_q; // [RULE2]
  wire gen_ovf = gen_adv && (gen_q == `UBG_GEN_TOP);
  assign gen_d = !gen_mode ? reload_val : // stopped timer presets from the reload bytes
                 (!gen_adv ? gen_q : (gen_ovf ? reload_val : 16'(gen_q + 16'h0001))); // [RULE3]

  // sixteen overflows per bit, counted per direction
  wire gen_tx_tick = gen_ovf && tx_sel && (tx_ovf_q == `UBG_OVF_LAST); // [RULE1]
  wire gen_rx_tick = gen_ovf && rx_sel && (rx_ovf_q == `UBG_OVF_LAST); // [RULE1]

  // eight-bit timer overflow path, halved count when rate doubling is set
  wire [4:0] t1_last = rate_double_bit ? `UBG_T1_LAST_X2 : `UBG_T1_LAST_X1;
  wire t1_tick = timer1_overflow && ((t1_q & t1_last) == t1_last);

  // fixed divisions for shift-register and fixed-rate nine-bit modes
  wire [5:0] fix_last = (mode == UBG_MODE_SHIFT) ? `UBG_SHIFT_LAST :
                        (rate_double_bit ? `UBG_FIX_LAST_X2 : `UBG_FIX_LAST_X1); // [RULE13]
  wire fix_tick = core_tick && (fix_q == fix_last); // [RULE13]
  assign fix_d = var_mode ? 6'h00 :
                 (!core_tick ? fix_q : (fix_tick ? 6'h00 : 6'(fix_q + 6'h01)));

  // source selection; dedicated timer wins over both clock selects
  ubg_src_type tx_src;
  ubg_src_type rx_src;
  assign tx_src = !var_mode ? UBG_SRC_FIXED : (baud_en ? UBG_SRC_DEDICATED : // [RULE6]
                  (tx_sel ? UBG_SRC_GENERAL : UBG_SRC_TIMER1)); // [RULE4]
  assign rx_src = !var_mode ? UBG_SRC_FIXED : (baud_en ? UBG_SRC_DEDICATED : // [RULE6]
                  (rx_sel ? UBG_SRC_GENERAL : UBG_SRC_TIMER1)); // [RULE4]

  // tick chosen from a source code, once per direction
  function automatic logic pick_tick(input ubg_src_type src, input logic gen_t,
                                     input logic t1_t, input logic bt_t,
                                     input logic fix_t);
    case (src)
      UBG_SRC_FIXED: pick_tick = fix_t;
      UBG_SRC_TIMER1: pick_tick = t1_t;
      UBG_SRC_GENERAL: pick_tick = gen_t;
      UBG_SRC_DEDICATED: pick_tick = bt_t;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  wire tx_d = pick_tick(tx_src, gen_tx_tick, t1_tick, bt_tick, fix_tick);
  wire rx_d = pick_tick(rx_src, gen_rx_tick, t1_tick, bt_tick, fix_tick);

  // read multiplexer; unmapped offsets read as zero
  wire [31:0] rmux =
    (wb_adr_i == `UBG_ADR_GEN_CTRL) ? {24'h00_0000, gen_ctrl_q} :
    (wb_adr_i == `UBG_ADR_RELOAD_LO) ? {24'h00_0000, reload_lo_q} :
    (wb_adr_i == `UBG_ADR_RELOAD_HI) ? {24'h00_0000, reload_hi_q} :
    (wb_adr_i == `UBG_ADR_BAUD_CTRL) ? {24'h00_0000, baud_ctrl_q} :
    (wb_adr_i == `UBG_ADR_FRAC_DIV) ? {24'h00_0000, frac_div_q} :
    (wb_adr_i == `UBG_ADR_POWER) ? {24'h00_0000, power_q} :
    (wb_adr_i == `UBG_ADR_CLOCK) ? {24'h00_0000, clock_ctrl_q} :
    (wb_adr_i == `UBG_ADR_COUNT) ? {16'h0000, gen_q} :
    (wb_adr_i == `UBG_ADR_SOURCE) ? {28'h000_0000, rx_src, tx_src} :
    32'h0000_0000;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign tx_bit_tick = tx_q;
  assign rx_bit_tick = rx_q;

  // bus handshake: ack one cycle after the request, dropped the next
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req && !ack_q;
      rdat_q <= (bus_req && !ack_q) ? rmux : rdat_q;
    end
  end

  // general timer control and reload bytes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gen_ctrl_q <= `UBG_RST_BYTE;
      reload_lo_q <= `UBG_RST_BYTE;
      reload_hi_q <= `UBG_RST_BYTE;
    end else begin
      gen_ctrl_q <= wr_gen ? wbyte : gen_ctrl_q;
      reload_lo_q <= wr_lo ? wbyte : reload_lo_q;
      reload_hi_q <= wr_hi ? wbyte : reload_hi_q;
    end
  end

  // dedicated timer, power and clock control; reserved bits stay zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      baud_ctrl_q <= `UBG_RST_BYTE; // [RULE14]
      frac_div_q <= `UBG_RST_BYTE;
      power_q <= `UBG_RST_BYTE;
      clock_ctrl_q <= `UBG_RST_BYTE;
    end else begin
      baud_ctrl_q <= wr_baud ? {wbyte[7], 4'h0, wbyte[2:0]} : baud_ctrl_q;
      frac_div_q <= wr_fd ? wbyte : frac_div_q;
      power_q <= wr_pwr ? {wbyte[7], 7'h00} : power_q;
      clock_ctrl_q <= wr_clk ? {5'h00, wbyte[2:0]} : clock_ctrl_q;
    end
  end

  // core divider and general timer counting
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cd_q <= 7'h00;
      gen_q <= `UBG_RST_COUNT;
      gen_phase_q <= 1'b0;
    end else begin
      cd_q <= 7'(cd_q + 7'h01);
      gen_q <= gen_d; // [RULE5]
      gen_phase_q <= (gen_mode && core_tick) ? !gen_phase_q : gen_phase_q; // [RULE2]
    end
  end

  // overflow dividers for the general timer and timer1 paths
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_ovf_q <= 4'h0;
      rx_ovf_q <= 4'h0;
      t1_q <= 5'h00;
    end else begin
      tx_ovf_q <= (gen_ovf && tx_sel) ? 4'(tx_ovf_q + 4'h1) : tx_ovf_q; // [RULE1]
      rx_ovf_q <= (gen_ovf && rx_sel) ? 4'(rx_ovf_q + 4'h1) : rx_ovf_q; // [RULE1]
      t1_q <= timer1_overflow ? 5'(t1_q + 5'h01) : t1_q;
    end
  end

  // fixed divider and registered tick outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fix_q <= 6'h00;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      fix_q <= fix_d;
      tx_q <= tx_d; // [RULE13]
      rx_q <= rx_d; // [RULE13]
    end
  end

  // dedicated fractional-divider baud timer
  ubg_frac_timer #(
    .FD_WIDTH(FD_WIDTH)
  ) u_frac (
    .clock(clock),
    .reset(reset),
    .core_tick(core_tick),
    .enable(baud_en), // [RULE6]
    .div_sel(bt_div),
    .frac_div(frac_div_q),
    .bit_tick(bt_tick)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_GEN_SIXTEEN: assert property ( // [RULE1]
    gen_tx_tick |-> gen_ovf && tx_ovf_q == 4'hf ##1 tx_ovf_q == 4'h0)
    else $error("general tx tick not on the sixteenth overflow");

  AST_GEN_HALF_RATE: assert property (gen_adv |=> !gen_adv) // [RULE2]
    else $error("general timer advanced on two cycles in a row");

  AST_GEN_RELOAD: assert property ( // [RULE3]
    gen_adv && gen_q == 16'hffff && !wr_lo && !wr_hi |=> gen_q == $past(reload_val))
    else $error("general timer did not reload on overflow");

  AST_GEN_STEP: assert property ( // [RULE5]
    gen_adv && gen_q != 16'hffff |=> gen_q == 16'($past(gen_q) + 16'h0001))
    else $error("general timer did not step by one");

  AST_TX_SELECT: assert property ( // [RULE4]
    var_mode && !baud_en && tx_sel |=> tx_bit_tick == $past(gen_tx_tick))
    else $error("tx tick not taken from the general timer");

  AST_RX_SELECT: assert property ( // [RULE4]
    var_mode && !baud_en && !rx_sel |=> rx_bit_tick == $past(t1_tick))
    else $error("rx tick not taken from the timer1 path");

  AST_DEDICATED_WINS: assert property ( // [RULE6]
    var_mode && baud_en |=> tx_bit_tick == $past(bt_tick) && rx_bit_tick == $past(bt_tick))
    else $error("dedicated timer enabled but not driving both ticks");

  AST_CORE_DIVIDE: assert property ( // [RULE12]
    core_tick && cd_sel != 3'h0 && $stable(cd_sel) && !wr_clk |=> !core_tick)
    else $error("core tick repeated with a divided core clock");

  AST_FIXED_MODES: assert property ( // [RULE13]
    !var_mode && $past(!var_mode) |-> (tx_bit_tick == rx_bit_tick))
    else $error("fixed modes gave differing tx and rx ticks");

  AST_RESET_DISABLED: assert property ($past(reset) |-> !baud_en) // [RULE14]
    else $error("dedicated timer enabled right after reset");

  AST_TX_OVF_COUNT: assert property ( // [RULE1]
    gen_ovf && tx_sel |=> tx_ovf_q == 4'($past(tx_ovf_q) + 4'h1))
    else $error("tx overflow divider did not count the overflow");

  AST_RX_OVF_COUNT: assert property ( // [RULE1]
    gen_ovf && rx_sel |=> rx_ovf_q == 4'($past(rx_ovf_q) + 4'h1))
    else $error("rx overflow divider did not count the overflow");

  AST_GEN_HOLD: assert property ( // [RULE2]
    gen_mode && !gen_adv |=> gen_q == $past(gen_q))
    else $error("general timer moved between its half-rate steps");

  AST_GEN_PRESET: assert property ( // [RULE3]
    !gen_mode |=> gen_q == $past(reload_val))
    else $error("stopped general timer did not follow the reload bytes");

  AST_GEN_IDLE: assert property ( // [RULE4]
    !gen_mode |-> !gen_tx_tick && !gen_rx_tick)
    else $error("general timer ticked while not in baud generator mode");

  AST_RX_GENERAL: assert property ( // [RULE4]
    var_mode && !baud_en && rx_sel |=> rx_bit_tick == $past(gen_rx_tick))
    else $error("rx tick not taken from the general timer");

  AST_TX_TIMER1: assert property ( // [RULE4]
    var_mode && !baud_en && !tx_sel |=> tx_bit_tick == $past(t1_tick))
    else $error("tx tick not taken from the timer1 path");

  AST_DEDICATED_OFF: assert property ( // [RULE6]
    !baud_en |=> !bt_tick)
    else $error("dedicated timer ticked while disabled");

  AST_BAUD_WRITE: assert property ( // [RULE7]
    wr_baud |=> bt_div == $past(wbyte[2:0]) && baud_en == $past(wbyte[7]))
    else $error("baud timer control write not taken");

  AST_CORE_UNDIVIDED: assert property ( // [RULE12]
    cd_sel == 3'h0 |-> core_tick)
    else $error("core tick missing with an undivided core clock");

  AST_FIXED_WRAP: assert property ( // [RULE13]
    fix_tick && !var_mode |=> fix_q == 6'h00)
    else $error("fixed divider did not wrap after its tick");

  AST_VAR_FIXED_IDLE: assert property ( // [RULE13]
    var_mode |=> fix_q == 6'h00)
    else $error("fixed divider ran in a variable-rate mode");

  AST_FIXED_SOURCE: assert property ( // [RULE13]
    !var_mode |=> tx_bit_tick == $past(fix_tick))
    else $error("fixed mode tick not taken from the fixed divider");

endmodule

// ===== tb/ubg_serial_model.sv
`timescale 1ns/1ns

module ubg_serial_model (
  // system
  input wire logic clock,
  input wire logic reset,
  // bit-rate ticks from the generator
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  // measured spacing and tick counts
  output logic [31:0] tx_period,
  output logic [31:0] rx_period,
  output logic [31:0] tx_ticks,
  output logic [31:0] rx_ticks
);
  logic [31:0] tx_gap_q;
  logic [31:0] rx_gap_q;

  // shift logic only sees tick spacing; it times each bit cell in clocks
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_gap_q <= 32'h0000_0000;
      rx_gap_q <= 32'h0000_0000;
      tx_period <= 32'h0000_0000;
      rx_period <= 32'h0000_0000;
      tx_ticks <= 32'h0000_0000;
      rx_ticks <= 32'h0000_0000;
    end else begin
      tx_gap_q <= tx_bit_tick ? 32'h0000_0001 : tx_gap_q + 32'h0000_0001;
      rx_gap_q <= rx_bit_tick ? 32'h0000_0001 : rx_gap_q + 32'h0000_0001;
      if (tx_bit_tick) begin
        tx_period <= tx_gap_q;
        tx_ticks <= tx_ticks + 32'h0000_0001;
      end
      if (rx_bit_tick) begin
        rx_period <= rx_gap_q;
        rx_ticks <= rx_ticks + 32'h0000_0001;
      end
    end
  end
endmodule

// ===== tb/ubg_baud_gen_test.sv
`timescale 1ns/1ns
`include "ubg_consts.svh"

module ubg_baud_gen_test;
  import ubg_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] serial_mode = 2'b00;
  logic timer1_overflow = 1'b0;
  logic tx_bit_tick;
  logic rx_bit_tick;
  logic [31:0] tx_period;
  logic [31:0] rx_period;
  logic [31:0] tx_ticks;
  logic [31:0] rx_ticks;
  logic [1:0] t1_cnt = 2'b00;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  ubg_baud_gen ubg_baud_gen_inst (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_mode(serial_mode), .timer1_overflow(timer1_overflow),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick));

  ubg_serial_model ubg_serial_model_inst (.clock(clock), .reset(reset),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick), .tx_period(tx_period),
    .rx_period(rx_period), .tx_ticks(tx_ticks), .rx_ticks(rx_ticks));

  // 25 MHz clock
  always #20 clock = ~clock;

  // eight-bit timer overflows every fourth clock
  always @(posedge clock) begin
    t1_cnt <= t1_cnt + 2'b01;
    timer1_overflow <= (t1_cnt == 2'b11);
  end

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle: hold everything until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wdat;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    check("ack latency", 32'(n), 32'h0000_0002);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] r;
    wb_cycle(1'b1, adr, 4'hf, {24'h00_0000, d}, r);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    wb_cycle(1'b0, adr, 4'hf, 32'h0000_0000, d);
  endtask

  // let three ticks pass per direction, then the latest spacing must be steady
  task automatic measure(input int exp_tx, input int exp_rx, input int limit);
    logic [31:0] t0;
    logic [31:0] r0;
    int n;
    t0 = tx_ticks;
    r0 = rx_ticks;
    n = 0;
    while ((tx_ticks < t0 + 3 || rx_ticks < r0 + 3) && n < limit) begin
      @(posedge clock);
      n++;
    end
    check("tick wait", 32'(n >= limit), 32'h0000_0000);
    check("tx period", tx_period, 32'(exp_tx));
    check("rx period", rx_period, 32'(exp_rx));
  endtask

  // odd fractions alternate two spacings; two cells together are exact
  task automatic measure_pair(input int exp_sum, input int limit);
    logic [31:0] t0;
    logic [31:0] tx_prev;
    logic [31:0] rx_prev;
    int n;
    t0 = tx_ticks;
    tx_prev = 32'h0000_0000;
    rx_prev = 32'h0000_0000;
    n = 0;
    while (tx_ticks < t0 + 4 && n < limit) begin
      @(posedge clock);
      n++;
      if (tx_ticks == t0 + 3) begin
        tx_prev = tx_period;
        rx_prev = rx_period;
      end
    end
    check("tick wait", 32'(n >= limit), 32'h0000_0000);
    check("tx pair", tx_prev + tx_period, 32'(exp_sum));
    check("rx pair", rx_prev + rx_period, 32'(exp_sum));
  endtask

  logic [31:0] v;
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(`UBG_ADR_BAUD_CTRL, v); check("baud ctrl reset", v, 32'h0000_0000);
    rd(`UBG_ADR_SOURCE, v); check("source reset", v, 32'h0000_0000);
    serial_mode <= UBG_MODE_VAR8;
    rd(`UBG_ADR_SOURCE, v); check("source timer1", v, 32'h0000_0005);
    measure(128, 128, 2000);
    wr(`UBG_ADR_BAUD_CTRL, 8'hff);
    rd(`UBG_ADR_BAUD_CTRL, v); check("baud ctrl rw", v, 32'h0000_0087);
    // divider and fraction chosen as software would
    wr(`UBG_ADR_BAUD_CTRL, 8'h80);
    wr(`UBG_ADR_FRAC_DIV, 8'h00);
    measure(32, 32, 1000);
    wr(`UBG_ADR_GEN_CTRL, 8'h34);
    wr(`UBG_ADR_POWER, 8'h80);
    rd(`UBG_ADR_SOURCE, v); check("source override", v, 32'h0000_000f);
    measure(32, 32, 1000);
    wr(`UBG_ADR_BAUD_CTRL, 8'h81);
    wr(`UBG_ADR_FRAC_DIV, 8'h09);
    measure_pair(146, 1000);
    wr(`UBG_ADR_BAUD_CTRL, 8'h80);
    wr(`UBG_ADR_FRAC_DIV, 8'h02);
    measure(33, 33, 1000);
    wr(`UBG_ADR_FRAC_DIV, 8'h00);
    wr(`UBG_ADR_CLOCK, 8'h01);
    measure(64, 64, 1000);
    wr(`UBG_ADR_CLOCK, 8'h00);
    wb_cycle(1'b1, `UBG_ADR_BAUD_CTRL, 4'h0, 32'h0000_0000, v);
    rd(`UBG_ADR_BAUD_CTRL, v); check("masked write", v, 32'h0000_0080);
    rd(8'h24, v); check("unmapped read", v, 32'h0000_0000);
    // general timer on tx only, rx stays on the eight-bit timer
    wr(`UBG_ADR_BAUD_CTRL, 8'h00);
    wr(`UBG_ADR_POWER, 8'h00);
    wr(`UBG_ADR_GEN_CTRL, 8'h00);
    wr(`UBG_ADR_RELOAD_LO, 8'hff);
    wr(`UBG_ADR_RELOAD_HI, 8'hff);
    wr(`UBG_ADR_GEN_CTRL, 8'h14);
    rd(`UBG_ADR_SOURCE, v); check("source split", v, 32'h0000_0006);
    measure(32, 128, 1000);
    wr(`UBG_ADR_RELOAD_LO, 8'hfe);
    measure(64, 128, 1000);
    serial_mode <= UBG_MODE_FIX9;
    measure(64, 64, 1000);
    wr(`UBG_ADR_POWER, 8'h80);
    measure(32, 32, 1000);
    serial_mode <= UBG_MODE_SHIFT;
    measure(12, 12, 1000);
    // nine-bit variable mode, rx on the doubled eight-bit timer path
    serial_mode <= UBG_MODE_VAR9;
    measure(64, 64, 1000);
    summarize();
  end
endmodule
